//--- design/page_mode_external_bus.sv
// page-mode external memory bus sequencer with strobe, latch-enable and stretch timing
//
// Behaviour
// RULE1: page mode enable set uses page timing; clear uses the conventional multiplexed bus.
// RULE2: page select 00/01/10 picks hit/miss lengths 1/2, 2/4, 4/8; 11 structure two.
// RULE3: first structure: high port carries both address bytes, low port is data.
// RULE4: fetches float the low port; opcode captured as the fetch strobe rises.
// RULE5: data reads float the low port; data writes drive it.
// RULE6: upper byte differing from stored page is a miss of 2, 4 or 8 clocks.
// RULE7: upper byte equal to stored page is a hit of 1, 2 or 4 clocks.
// RULE8: on a hit the high port shows the low byte and latch enable stays low.
// RULE9: miss first half: upper byte out, latch enable high, strobes off, low port floats.
// RULE10: after the miss latch half, the rest runs as a hit cycle.
// RULE11: each new page is stored and compared; the first access misses.
// RULE12: select 00: fetch strobe low one full clock on hits and misses.
// RULE13: select 00: data moves miss, and so does the following fetch.
// RULE14: one-cycle mode: fetch strobe stays low across back-to-back hit fetches.
// RULE15: two-cycle mode: fetch strobe one clock; data upper byte change misses.
// RULE16: four-cycle mode: data moves compare against the stored page, no forced miss.
// RULE17: structure two: upper byte and data share high port, low byte on low port.
// RULE18: structure two: data cycles use conventional timing, only port roles differ.
// RULE19: structure two: data accesses take four clocks hit or miss.
// RULE20: data cycles stretch by whole stretch cycles of four clocks.
// RULE21: stretch codes 000-011 give 0-3 cycles, 100-111 give 7-10.
// RULE22: select 00/01 at divide by one: strobe 1,3,7,11,15,19,23,27 clocks.
// RULE23: strobe width in oscillator clocks scales with the system clock setting.
// RULE24: external latches capture the upper byte on latch enable and hold it.
// RULE25: stored page is updated on every miss, code or data.
`timescale 1ns/10ps
module page_mode_external_bus (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic pageModeEnable,
    input wire logic [1:0] pageSelect,
    input wire logic [2:0] stretchSelect,
    input wire logic reqValid,
    input wire logic [1:0] reqKind,
    input wire logic [15:0] reqAddr,
    input wire logic [7:0] reqWdata,
    output logic reqReady,
    output logic rspValid,
    output logic [7:0] rspData,
    input wire logic [7:0] lowPortIn,
    output logic [7:0] lowPortOut,
    output logic lowPortOe,
    input wire logic [7:0] highPortIn,
    output logic [7:0] highPortOut,
    output logic highPortOe,
    output logic addrLatchEn,
    output logic codeFetchStrobeN,
    output logic readStrobeN,
    output logic writeStrobeN
);
    localparam int CW = page_bus_pkg::CNT_W;

    page_bus_pkg::phase_t phase_q;
    page_bus_pkg::phase_t phase_d;
    logic [CW-1:0] pos_q;
    logic [CW-1:0] pos_d;
    page_bus_pkg::kind_t kind_q;
    page_bus_pkg::bus_mode_t mode_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [CW-1:0] latchLen_q;
    logic [CW-1:0] accessLen_q;
    logic [CW-1:0] stbSetup_q;
    logic [CW-1:0] stbWidth_q;
    logic ready_q;
    logic missNow;

    // new cycle descriptor
    page_bus_pkg::kind_t newKind;
    page_bus_pkg::bus_mode_t newMode;
    logic [CW-1:0] hitLen;
    logic [CW-1:0] newLatch;
    logic [CW-1:0] newAccess;
    logic [CW-1:0] newWidth;
    logic [CW-1:0] newSetup;

    assign newKind = page_bus_pkg::kind_t'(reqKind);
    wire logic newFetch = newKind == page_bus_pkg::KIND_FETCH;
    wire logic start = clkEn && reqValid && ready_q;
    wire logic narrowSel = (pageSelect == page_bus_pkg::SEL_1CYC)
                           || (pageSelect == page_bus_pkg::SEL_2CYC);
    wire logic [CW-1:0] stretchClks = page_bus_pkg::stretch_clocks(stretchSelect); // [RULE20] [RULE21]
    wire logic [CW-1:0] dataWidth = page_bus_pkg::data_strobe_width(stretchSelect); // [RULE22]
    wire logic [CW-1:0] lastAccess = accessLen_q - 6'h01;
    wire logic [CW-1:0] lastLatch = latchLen_q - 6'h01;
    wire logic lastClk = (phase_q == page_bus_pkg::PH_ACCESS) && (pos_q == lastAccess);

    assign newMode = !pageModeEnable ? page_bus_pkg::MODE_NONPAGE :
                     (pageSelect == page_bus_pkg::SEL_MODE2) ? page_bus_pkg::MODE_PAGE2 :
                     page_bus_pkg::MODE_PAGE1; // [RULE1] [RULE2]
    assign hitLen = (pageSelect == page_bus_pkg::SEL_1CYC) ? page_bus_pkg::HIT_LEN_1CYC :
                    (pageSelect == page_bus_pkg::SEL_2CYC) ? page_bus_pkg::HIT_LEN_2CYC :
                    page_bus_pkg::HIT_LEN_4CYC; // [RULE2] [RULE7]

    page_tracker u_tracker (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .pageModeEnable(pageModeEnable),
        .pageSelect(pageSelect),
        .lookupUpper(reqAddr[15:8]),
        .lookupData(!newFetch),
        .commit(start),
        .miss(missNow)
    );

    always_comb begin
        newLatch = page_bus_pkg::NONPAGE_LATCH_LEN;
        newAccess = page_bus_pkg::NONPAGE_ACCESS_LEN;
        newWidth = page_bus_pkg::FETCH_STROBE_WIDE;
        unique case (newMode)
            page_bus_pkg::MODE_PAGE1: begin
                // a miss is a latch half as long as the unstretched hit cycle that follows it
                newLatch = missNow ? hitLen : page_bus_pkg::NO_LATCH_LEN; // [RULE6] [RULE10]
                newAccess = newFetch ? hitLen : hitLen + stretchClks; // [RULE20]
                if (newFetch) begin
                    newWidth = narrowSel ? page_bus_pkg::FETCH_STROBE_NARROW
                                         : page_bus_pkg::FETCH_STROBE_WIDE; // [RULE12] [RULE15]
                end else begin
                    newWidth = narrowSel ? dataWidth
                                         : dataWidth + page_bus_pkg::DATA_STROBE_EXTRA; // [RULE22]
                end
            end
            page_bus_pkg::MODE_PAGE2: begin
                if (newFetch) begin
                    newLatch = missNow ? page_bus_pkg::MODE2_HALF_LEN
                                       : page_bus_pkg::NO_LATCH_LEN; // [RULE2] [RULE17]
                    newAccess = page_bus_pkg::MODE2_HALF_LEN;
                    newWidth = page_bus_pkg::FETCH_STROBE_NARROW;
                end else begin
                    // data moves run the conventional four-clock timing
                    newAccess = page_bus_pkg::NONPAGE_ACCESS_LEN + stretchClks; // [RULE18] [RULE19]
                    newWidth = dataWidth + page_bus_pkg::DATA_STROBE_EXTRA;
                end
            end
            page_bus_pkg::MODE_NONPAGE: begin
                if (!newFetch) begin
                    newAccess = page_bus_pkg::NONPAGE_ACCESS_LEN + stretchClks; // [RULE1]
                    newWidth = dataWidth + page_bus_pkg::DATA_STROBE_EXTRA;
                end
            end
            default: begin
                newLatch = page_bus_pkg::NONPAGE_LATCH_LEN;
            end
        endcase
        // fetch strobe ends with the cycle so its rising edge captures the opcode
        newSetup = newFetch ? newAccess - newWidth
                            : (newAccess - newWidth) >> 1; // [RULE4] [RULE23]
    end

    // descriptor seen by the next cycle
    wire page_bus_pkg::kind_t curKind = start ? newKind : kind_q;
    wire page_bus_pkg::bus_mode_t curMode = start ? newMode : mode_q;
    wire logic [15:0] curAddr = start ? reqAddr : addr_q;
    wire logic [7:0] curWdata = start ? reqWdata : wdata_q;
    wire logic [CW-1:0] curAccess = start ? newAccess : accessLen_q;
    wire logic [CW-1:0] curSetup = start ? newSetup : stbSetup_q;
    wire logic [CW-1:0] curWidth = start ? newWidth : stbWidth_q;

    always_comb begin
        phase_d = phase_q;
        pos_d = pos_q;
        if (start) begin
            phase_d = (newLatch != page_bus_pkg::NO_LATCH_LEN) ? page_bus_pkg::PH_LATCH
                                                               : page_bus_pkg::PH_ACCESS; // [RULE8]
            pos_d = '0;
        end else begin
            unique case (phase_q)
                page_bus_pkg::PH_LATCH: begin
                    if (pos_q == lastLatch) begin
                        phase_d = page_bus_pkg::PH_ACCESS; // [RULE10]
                        pos_d = '0;
                    end else begin
                        pos_d = pos_q + 6'h01;
                    end
                end
                page_bus_pkg::PH_ACCESS: begin
                    if (lastClk) begin
                        phase_d = page_bus_pkg::PH_IDLE;
                        pos_d = '0;
                    end else begin
                        pos_d = pos_q + 6'h01;
                    end
                end
                page_bus_pkg::PH_IDLE: begin
                    pos_d = '0;
                end
                default: begin
                    phase_d = page_bus_pkg::PH_IDLE;
                end
            endcase
        end
    end

    // ready in the last access clock lets a hit fetch follow with no gap
    wire logic ready_d = (phase_d == page_bus_pkg::PH_IDLE)
                         || ((phase_d == page_bus_pkg::PH_ACCESS)
                             && (pos_d == curAccess - 6'h01)); // [RULE14]

    // pin values for the next cycle
    wire logic nextLatch = phase_d == page_bus_pkg::PH_LATCH;
    wire logic nextAccess = phase_d == page_bus_pkg::PH_ACCESS;
    wire logic strobeOn = nextAccess && (pos_d >= curSetup)
                          && (pos_d < curSetup + curWidth); // [RULE12] [RULE22]
    wire logic fetchStbN_d = !(strobeOn && (curKind == page_bus_pkg::KIND_FETCH)); // [RULE9]
    wire logic readStbN_d = !(strobeOn && (curKind == page_bus_pkg::KIND_READ)); // [RULE9]
    wire logic writeStbN_d = !(strobeOn && (curKind == page_bus_pkg::KIND_WRITE)); // [RULE9]
    wire logic isWrite = curKind == page_bus_pkg::KIND_WRITE;

    logic [7:0] lowOut_d;
    logic lowOe_d;
    logic [7:0] highOut_d;
    logic highOe_d;

    always_comb begin
        lowOut_d = 8'h00;
        lowOe_d = 1'b0;
        highOut_d = curAddr[15:8];
        highOe_d = nextLatch || nextAccess;
        unique case (curMode)
            page_bus_pkg::MODE_PAGE1: begin
                // latch half floats the low port; access half shows the low byte up top
                if (nextAccess) begin
                    highOut_d = curAddr[7:0]; // [RULE3] [RULE8]
                    lowOut_d = curWdata;
                    lowOe_d = isWrite; // [RULE4] [RULE5] [RULE9]
                end
            end
            page_bus_pkg::MODE_PAGE2: begin
                lowOut_d = curAddr[7:0];
                lowOe_d = nextLatch || nextAccess; // [RULE17]
                if (nextAccess) begin
                    highOut_d = curWdata;
                    highOe_d = isWrite; // [RULE17] [RULE18]
                end
            end
            page_bus_pkg::MODE_NONPAGE: begin
                lowOut_d = nextLatch ? curAddr[7:0] : curWdata;
                lowOe_d = nextLatch || (nextAccess && isWrite); // [RULE1]
            end
            default: begin
                highOe_d = 1'b0;
            end
        endcase
    end

    wire logic capture = lastClk && (kind_q != page_bus_pkg::KIND_WRITE);
    wire logic [CW-1:0] lastStrobe = stbSetup_q + stbWidth_q - 6'h01;
    wire logic strobeEnd = (phase_q == page_bus_pkg::PH_ACCESS) && (pos_q == lastStrobe);
    wire logic [7:0] captureData = (mode_q == page_bus_pkg::MODE_PAGE2) ? highPortIn
                                                                       : lowPortIn;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= page_bus_pkg::PH_IDLE;
            pos_q <= '0;
            ready_q <= 1'b0;
        end else if (clkEn) begin
            phase_q <= phase_d;
            pos_q <= pos_d;
            ready_q <= ready_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            kind_q <= page_bus_pkg::KIND_FETCH;
            mode_q <= page_bus_pkg::MODE_NONPAGE;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            latchLen_q <= page_bus_pkg::NO_LATCH_LEN;
            accessLen_q <= page_bus_pkg::HIT_LEN_1CYC;
            stbSetup_q <= '0;
            stbWidth_q <= page_bus_pkg::FETCH_STROBE_NARROW;
        end else if (start) begin
            kind_q <= newKind;
            mode_q <= newMode;
            addr_q <= reqAddr;
            wdata_q <= reqWdata;
            latchLen_q <= newLatch;
            accessLen_q <= newAccess;
            stbSetup_q <= newSetup;
            stbWidth_q <= newWidth;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addrLatchEn <= 1'b0;
            codeFetchStrobeN <= 1'b1;
            readStrobeN <= 1'b1;
            writeStrobeN <= 1'b1;
            lowPortOut <= 8'h00;
            lowPortOe <= 1'b0;
            highPortOut <= 8'h00;
            highPortOe <= 1'b0;
            rspValid <= 1'b0;
            rspData <= 8'h00;
        end else if (clkEn) begin
            addrLatchEn <= nextLatch; // [RULE9]
            codeFetchStrobeN <= fetchStbN_d;
            readStrobeN <= readStbN_d;
            writeStrobeN <= writeStbN_d;
            lowPortOut <= lowOut_d;
            lowPortOe <= lowOe_d;
            highPortOut <= highOut_d;
            highPortOe <= highOe_d;
            rspValid <= capture;
            if (strobeEnd && (kind_q != page_bus_pkg::KIND_WRITE)) begin
                rspData <= captureData; // [RULE4]
            end
        end
    end

    assign reqReady = ready_q;

    wire logic p1Req = start && (newMode == page_bus_pkg::MODE_PAGE1);
    wire logic p1Fetch = p1Req && newFetch;

    a_hit_no_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (start && !missNow && pageModeEnable) |=> !addrLatchEn) // [RULE8]
        else $error("latch enable raised on a page hit");

    a_miss_latch_half: assert property (@(posedge clk_sys) disable iff (!rst_b)
        p1Req && missNow |=> addrLatchEn && codeFetchStrobeN && readStrobeN
                             && writeStrobeN && !lowPortOe
                             && (highPortOut == $past(reqAddr[15:8]))) // [RULE9]
        else $error("miss latch half shows wrong pins");

    a_hit_len_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (p1Fetch && !missNow && pageSelect == page_bus_pkg::SEL_1CYC && clkEn)
        |=> lastClk && !codeFetchStrobeN) // [RULE7] [RULE12]
        else $error("one-clock hit fetch wrong");

    a_miss_len_four: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (p1Fetch && missNow && pageSelect == page_bus_pkg::SEL_2CYC && clkEn)
        ##1 clkEn[*4] |-> !$past(lastClk) ##0 lastClk) // [RULE6]
        else $error("two-cycle mode miss not four clocks");

    a_miss_len_eight: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (p1Fetch && missNow && pageSelect == page_bus_pkg::SEL_4CYC && clkEn)
        ##1 clkEn[*8] |-> lastClk) // [RULE6] [RULE10]
        else $error("four-cycle mode miss not eight clocks");

    a_mode2_data_four: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (start && newMode == page_bus_pkg::MODE_PAGE2 && !newFetch && stretchSelect == 3'h0)
        ##1 clkEn[*4] |-> lastClk) // [RULE19]
        else $error("structure two data access not four clocks");

    a_forced_miss: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (p1Req && !newFetch && pageSelect == page_bus_pkg::SEL_1CYC) |-> missNow) // [RULE13]
        else $error("data move in one-cycle mode did not miss");

    a_read_floats: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (phase_q == page_bus_pkg::PH_ACCESS && mode_q == page_bus_pkg::MODE_PAGE1
         && kind_q != page_bus_pkg::KIND_WRITE) |-> !lowPortOe) // [RULE5] [RULE4]
        else $error("low port driven during read or fetch");

    a_write_drives: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (phase_q == page_bus_pkg::PH_ACCESS && mode_q == page_bus_pkg::MODE_PAGE1
         && kind_q == page_bus_pkg::KIND_WRITE)
        |-> lowPortOe && lowPortOut == wdata_q && highPortOut == addr_q[7:0]) // [RULE5] [RULE3]
        else $error("write data or low address byte missing");

    a_read_width_three: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (p1Req && newKind == page_bus_pkg::KIND_READ && pageSelect == page_bus_pkg::SEL_1CYC
         && stretchSelect == 3'h1 && clkEn) ##1 clkEn[*6]
        |-> $past(readStrobeN, 4) && !$past(readStrobeN, 3) && !$past(readStrobeN, 2)
            && !$past(readStrobeN, 1) && readStrobeN) // [RULE22] [RULE20]
        else $error("read strobe width wrong for stretch one");

endmodule

//--- common/page_bus_pkg.sv
// shared constants, types and stretch decoding for the page-mode external bus sequencer
package page_bus_pkg;

    localparam int CNT_W = 6;

    // page select codes
    localparam logic [1:0] SEL_1CYC = 2'h0;
    localparam logic [1:0] SEL_2CYC = 2'h1;
    localparam logic [1:0] SEL_4CYC = 2'h2;
    localparam logic [1:0] SEL_MODE2 = 2'h3;

    // cycle lengths in system clocks
    localparam logic [CNT_W-1:0] HIT_LEN_1CYC = 6'h01;
    localparam logic [CNT_W-1:0] HIT_LEN_2CYC = 6'h02;
    localparam logic [CNT_W-1:0] HIT_LEN_4CYC = 6'h04;
    localparam logic [CNT_W-1:0] MODE2_HALF_LEN = 6'h02;
    localparam logic [CNT_W-1:0] NONPAGE_LATCH_LEN = 6'h01;
    localparam logic [CNT_W-1:0] NONPAGE_ACCESS_LEN = 6'h03;
    localparam logic [CNT_W-1:0] NO_LATCH_LEN = 6'h00;
    localparam logic [CNT_W-1:0] STRETCH_CYCLE_CLKS = 6'h04;

    // strobe widths in system clocks
    localparam logic [CNT_W-1:0] FETCH_STROBE_NARROW = 6'h01;
    localparam logic [CNT_W-1:0] FETCH_STROBE_WIDE = 6'h02;
    localparam logic [CNT_W-1:0] DATA_STROBE_EXTRA = 6'h01;

    typedef enum logic [1:0] {
        KIND_FETCH = 2'b00,
        KIND_READ = 2'b01,
        KIND_WRITE = 2'b10
    } kind_t;

    typedef enum logic [1:0] {
        MODE_NONPAGE = 2'b00,
        MODE_PAGE1 = 2'b01,
        MODE_PAGE2 = 2'b10
    } bus_mode_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LATCH = 2'b01,
        PH_ACCESS = 2'b10
    } phase_t;

    // added clocks: codes 0..3 give 0..3 stretch cycles, codes 4..7 give 7..10
    function automatic logic [CNT_W-1:0] stretch_clocks(input logic [2:0] code);
        logic [CNT_W-1:0] n;
        n = {3'h0, code};
        if (code[2]) begin
            n = {3'h0, code} + 6'h03;
        end
        return n * STRETCH_CYCLE_CLKS;
    endfunction

    // data strobe width at one oscillator clock per system clock: 1,3,7,...,27
    function automatic logic [CNT_W-1:0] data_strobe_width(input logic [2:0] code);
        logic [CNT_W-1:0] w;
        w = 6'h01;
        if (code != 3'h0) begin
            w = ({3'h0, code} * 6'h04) - 6'h01;
        end
        return w;
    endfunction

endpackage

//--- design/page_tracker.sv
// stored page address and page hit or miss decision
`timescale 1ns/10ps
module page_tracker (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic pageModeEnable,
    input wire logic [1:0] pageSelect,
    input wire logic [7:0] lookupUpper,
    input wire logic lookupData,
    input wire logic commit,
    output logic miss
);
    logic [7:0] storedPage_q;
    logic pageValid_q;
    logic forceNext_q;
    wire logic mode2 = pageModeEnable && (pageSelect == page_bus_pkg::SEL_MODE2);
    wire logic oneCyc = pageModeEnable && (pageSelect == page_bus_pkg::SEL_1CYC);
    // data moves always miss in the one-cycle mode and in the second bus structure
    wire logic forcedData = lookupData && (oneCyc || mode2); // [RULE13] [RULE19]
    wire logic forcedFetch = !lookupData && forceNext_q; // [RULE13]
    wire logic pageDiffers = lookupUpper != storedPage_q; // [RULE6] [RULE7] [RULE16]

    // invalid page after reset or outside page mode makes the first access a miss
    assign miss = !pageModeEnable || !pageValid_q || forcedData || forcedFetch
                  || pageDiffers; // [RULE11]

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            storedPage_q <= 8'h00;
            pageValid_q <= 1'b0;
            forceNext_q <= 1'b0;
        end else if (clkEn && commit) begin
            if (miss) begin
                storedPage_q <= lookupUpper; // [RULE25] [RULE11]
            end
            pageValid_q <= pageModeEnable;
            forceNext_q <= lookupData && oneCyc; // [RULE13]
        end
    end

    a_page_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && commit && miss) |=> (storedPage_q == $past(lookupUpper))) // [RULE25]
        else $error("page register not loaded on a miss");

    a_fetch_after_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && commit && lookupData && oneCyc) ##2 (commit && !lookupData) |-> miss) // [RULE13]
        else $error("fetch after data move not forced to miss");

endmodule

//--- tb/ext_mem_model.sv
// external memory with upper address latch on the far side of the bus
`timescale 1ns/10ps
module ext_mem_model (
    input wire logic clk_sys,
    input wire logic mode2,
    input wire logic nonPage,
    input wire logic addrLatchEn,
    input wire logic [7:0] highPortOut,
    input wire logic [7:0] lowPortOut,
    input wire logic codeFetchStrobeN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    output logic [7:0] lowPortIn,
    output logic [7:0] highPortIn
);
    logic [7:0] upper_q = 8'h00;
    logic [7:0] lower_q = 8'h00;
    logic [7:0] mem [65536];
    // conventional bus: low byte latched from the low port, upper byte stays on the high port
    wire [15:0] addr = nonPage ? {highPortOut, lower_q}
                               : {upper_q, mode2 ? lowPortOut : highPortOut};
    wire rd = !codeFetchStrobeN || !readStrobeN;
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
    end
    // released lines show the inverse so a stale byte never passes as data
    assign lowPortIn = rd ? mem[addr] : ~mem[addr];
    assign highPortIn = lowPortIn;
    always @(posedge clk_sys) begin
        if (addrLatchEn) upper_q <= highPortOut;
        if (addrLatchEn) lower_q <= lowPortOut;
        if (!writeStrobeN) mem[addr] <= mode2 ? highPortOut : lowPortOut;
    end
endmodule

//--- tb/test_page_mode_external_bus.sv
// self-checking bench for the page-mode external bus sequencer
`timescale 1ns/10ps
module test_page_mode_external_bus;
    logic clk_sys = 0, rst_b = 0, reqValid = 0, pageModeEnable = 1;
    logic [1:0] pageSelect = 0, reqKind = 0;
    logic [2:0] stretchSelect = 0;
    logic [15:0] reqAddr = 0;
    logic [7:0] reqWdata = 0, lowPortIn, highPortIn, rspData, lowPortOut, highPortOut, page;
    logic reqReady, rspValid, lowPortOe, highPortOe, addrLatchEn, fetchN, readN, writeN;
    logic [7:0] shadow [65536];
    logic [7:0] expData [$];
    int expLen [$];
    time expT [$];
    int err_count = 0, compares = 0;
    bit pageValid = 0, forceMiss = 0;
    bit [31:0] rng = 78011;
    page_mode_external_bus i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(1'b1),
        .pageModeEnable(pageModeEnable), .pageSelect(pageSelect), .stretchSelect(stretchSelect),
        .reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .lowPortIn(lowPortIn),
        .lowPortOut(lowPortOut), .lowPortOe(lowPortOe), .highPortIn(highPortIn),
        .highPortOut(highPortOut), .highPortOe(highPortOe), .addrLatchEn(addrLatchEn),
        .codeFetchStrobeN(fetchN), .readStrobeN(readN), .writeStrobeN(writeN));
    ext_mem_model i_mem (.clk_sys(clk_sys), .mode2(pageSelect == 2'h3), .nonPage(!pageModeEnable),
        .addrLatchEn(addrLatchEn), .highPortOut(highPortOut), .lowPortOut(lowPortOut),
        .codeFetchStrobeN(fetchN), .readStrobeN(readN), .writeStrobeN(writeN),
        .lowPortIn(lowPortIn), .highPortIn(highPortIn));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    function automatic bit [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic issue(input logic [1:0] k, input logic [15:0] a, input logic [7:0] w,
                         input logic [1:0] sel, input logic [2:0] st);
        int h, n, len;
        bit miss;
        #1;
        h = (sel == 2'h0) ? 1 : (sel == 2'h1) ? 2 : 4;
        n = st[2] ? st + 3 : st;
        miss = !pageModeEnable || !pageValid || a[15:8] != page || forceMiss
               || ((sel == 2'h0 || sel == 2'h3) && k != 2'h0);
        if (!pageModeEnable) len = 4 + ((k == 2'h0) ? 0 : 4 * n);
        else if (sel == 2'h3) len = (k == 2'h0) ? (miss ? 4 : 2) : 4 + 4 * n;
        else len = (miss ? h : 0) + h + ((k == 2'h0) ? 0 : 4 * n);
        if (miss) page = a[15:8];
        pageValid = pageModeEnable;
        forceMiss = pageModeEnable && sel == 2'h0 && k != 2'h0;
        {pageSelect, stretchSelect, reqKind, reqAddr, reqWdata} = {sel, st, k, a, w};
        reqValid = 1;
        @(posedge clk_sys);
        while (reqReady !== 1'b1) @(posedge clk_sys);
        if (k == 2'h2) shadow[a] = w;
        else begin
            expData.push_back(shadow[a]);
            expLen.push_back(len);
            expT.push_back($time);
        end
    endtask
    always @(posedge clk_sys) begin
        if (rspValid === 1'b1) begin
            compares++;
            if (expData.size() == 0) begin
                err_count++;
                $display("unexpected rspValid expected 0 seen 1");
            end else begin
                if (rspData !== expData[0]) begin
                    err_count++;
                    $display("unexpected rspData expected %h seen %h", expData[0], rspData);
                end
                if (($time - expT[0]) / 20 != expLen[0] + 1) begin
                    err_count++;
                    $display("unexpected latency expected %0d seen %0d", expLen[0] + 1,
                             ($time - expT[0]) / 20);
                end
                void'(expData.pop_front());
                void'(expLen.pop_front());
                void'(expT.pop_front());
            end
        end
    end
    initial begin
        bit [31:0] r;
        for (int i = 0; i < 65536; i++) shadow[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
        repeat (10) @(posedge clk_sys);
        #1 rst_b = 1;
        repeat (2) @(posedge clk_sys);
        for (int s = 0; s < 5; s++) begin
            #1 reqValid = 0;
            repeat (60) @(posedge clk_sys);
            #1 pageModeEnable = s < 4;
            for (int i = 0; i < 40; i++) begin
                r = xs();
                issue((r[1:0] == 2'h3) ? 2'h0 : r[1:0], {r[8] ? 8'h12 : 8'h34, 5'h00, r[11:9]},
                      r[31:24], s[1:0], r[6:4]);
            end
        end
        #1 reqValid = 0;
        repeat (60) @(posedge clk_sys);
        compares++;
        if (expData.size() != 0) begin
            err_count++;
            $display("unexpected pending answers expected 0 seen %0d", expData.size());
        end
        finish_test();
    end
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule
